// file: mifc_top.sv
// Function
// - flag sets on source event or written 1
// - flag clears on written 0, acknowledge, reset
// - request flags reset to all zeros
// - flags and masks take bit or byte writes
// - mask 0 permits servicing, 1 blocks
// - mask registers reset to all ones
// - each of thirteen sources owns flag and mask
// - output-mode pin level change raises request
// - edge register 0 selects pins 0-2 edges
// - edge codes: 00 fall, 01 rise, 11 both
// - edge register 0 field layout, bits 1:0 zero
// - edge register 0 resets to zero
// - edge register 1 holds pin 3 field
// - edge register 1 resets to zero
// - edge registers accept byte writes only
// - request presented only when flagged and unmasked
// - highest fixed priority wins among pending
`timescale 1ns/1ps
`default_nettype none
`include "mifc_regs.svh"
module mifc_top (
   // clock, reset, enable
   input  wire logic                     ref_clk_in,
   input  wire logic                     reset_n_in,
   input  wire logic                     clk_en_in,
   // cpu register access
   input  wire logic [15:0]              cpu_addr_in,
   input  wire logic                     cpu_wr_in,
   input  wire logic                     cpu_rd_in,
   input  wire logic                     cpu_bit_op_in,
   input  wire logic [2:0]               cpu_bit_sel_in,
   input  wire logic                     cpu_bit_val_in,
   input  wire logic [7:0]               cpu_wdata_in,
   output logic [7:0]                    cpu_rdata_out,
   // acknowledge
   input  wire logic                     cpu_ack_in,
   input  wire logic [3:0]               cpu_ack_index_in,
   // internal sources, one-cycle pulses
   input  wire logic                     low_voltage_request_in,
   input  wire logic                     timer_h1_match_in,
   input  wire logic                     timer_00_ch0_in,
   input  wire logic                     timer_00_ch1_in,
   input  wire logic                     conversion_done_request_in,
   input  wire logic                     timer_80_match_in,
   input  wire logic                     serial_rx_error_request_in,
   input  wire logic                     serial_rx_done_request_in,
   input  wire logic                     serial_tx_done_request_in,
   // external pins, pad level whether driven from outside or by the port
   input  wire logic                     ext_irq_pin0_in,
   input  wire logic                     ext_irq_pin1_in,
   input  wire logic                     ext_irq_pin2_in,
   input  wire logic                     ext_irq_pin3_in,
   // request to core
   output logic                          irq_pending_out,
   output logic [3:0]                    irq_index_out,
   output logic [`MIFC_NUM_SRC-1:0]      request_flags_out,
   output logic [`MIFC_NUM_SRC-1:0]      mask_flags_out
);

   // reset words, cut to the implemented bits where used
   localparam logic [15:0]       RST_FLAGS_WORD = {`MIFC_RST_FLAGS, `MIFC_RST_FLAGS};
   localparam logic [15:0]       RST_MASK_WORD  = {`MIFC_RST_MASK, `MIFC_RST_MASK};

   logic [1:0]                   rst_pipe;
   logic                         rst_n;

   mifc_pkg::mifc_cpu_req_t      req;
   mifc_pkg::mifc_reg_t          reg_id;
   mifc_pkg::mifc_pick_t         pick;

   logic [`MIFC_NUM_SRC-1:0]     flags;
   logic [`MIFC_NUM_SRC-1:0]     masks;
   logic [`MIFC_NUM_SRC-1:0]     next_flags;
   logic [`MIFC_NUM_SRC-1:0]     next_masks;
   logic [`MIFC_NUM_SRC-1:0]     hw_set;
   logic [`MIFC_NUM_SRC-1:0]     ack_clr;

   logic [7:0]                   edge_sel0;
   logic [7:0]                   edge_sel1;
   logic [7:0]                   cur_byte;
   logic [7:0]                   wr_byte;

   logic [3:0]                   pin_level;
   logic [3:0]                   pin_hit;
   logic [3:0][1:0]              pin_sel;

   logic                         wr_hit;
   logic                         flag_access;

   // address decode shared by read, write and the pending hold
   function automatic mifc_pkg::mifc_reg_t decode_addr(input logic [15:0] addr);
      case (addr)
         `MIFC_ADDR_FLAGS_LO:  decode_addr = mifc_pkg::REG_FLAGS_LO;
         `MIFC_ADDR_FLAGS_HI:  decode_addr = mifc_pkg::REG_FLAGS_HI;
         `MIFC_ADDR_MASK_LO:   decode_addr = mifc_pkg::REG_MASK_LO;
         `MIFC_ADDR_MASK_HI:   decode_addr = mifc_pkg::REG_MASK_HI;
         `MIFC_ADDR_EDGE_SEL0: decode_addr = mifc_pkg::REG_EDGE_SEL0;
         `MIFC_ADDR_EDGE_SEL1: decode_addr = mifc_pkg::REG_EDGE_SEL1;
         default:              decode_addr = mifc_pkg::REG_NONE;
      endcase
   endfunction : decode_addr

   // reset release through two flops; not gated by the enable so reset always completes
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_n = rst_pipe[1];

   assign req.addr    = cpu_addr_in;
   assign req.wr      = cpu_wr_in;
   assign req.rd      = cpu_rd_in;
   assign req.bit_op  = cpu_bit_op_in;
   assign req.bit_sel = cpu_bit_sel_in;
   assign req.bit_val = cpu_bit_val_in;
   assign req.wdata   = cpu_wdata_in;

   assign reg_id = decode_addr(req.addr);

   // current contents of the addressed register; unmapped reads as zero
   always_comb begin
      case (reg_id)
         mifc_pkg::REG_FLAGS_LO:  cur_byte = flags[7:0];
         mifc_pkg::REG_FLAGS_HI:  cur_byte = {3'h0, flags[`MIFC_NUM_SRC-1:8]};
         mifc_pkg::REG_MASK_LO:   cur_byte = masks[7:0];
         mifc_pkg::REG_MASK_HI:   cur_byte = {3'h7, masks[`MIFC_NUM_SRC-1:8]};
         mifc_pkg::REG_EDGE_SEL0: cur_byte = edge_sel0;
         mifc_pkg::REG_EDGE_SEL1: cur_byte = edge_sel1;
         default:                 cur_byte = 8'h00;
      endcase
   end

   // bit manipulation is read-modify-write of the addressed byte
   always_comb begin
      wr_byte = req.wdata;
      if (req.bit_op) begin
         wr_byte = cur_byte;
         wr_byte[req.bit_sel] = req.bit_val;
      end
   end

   assign wr_hit = req.wr & clk_en_in;

   // pin edge detectors
   assign pin_level = {ext_irq_pin3_in, ext_irq_pin2_in, ext_irq_pin1_in, ext_irq_pin0_in};
   assign pin_sel[0] = edge_sel0[`MIFC_PIN0_EDGE_LSB +: 2];
   assign pin_sel[1] = edge_sel0[`MIFC_PIN1_EDGE_LSB +: 2];
   assign pin_sel[2] = edge_sel0[`MIFC_PIN2_EDGE_LSB +: 2];
   assign pin_sel[3] = edge_sel1[`MIFC_PIN3_EDGE_LSB +: 2];

   generate
      for (genvar p = 0; p < 4; p++) begin : g_pin
         // sees the pad, so a level change driven in output mode counts too
         mifc_edge_detect u_edge (
            .clk_in      (ref_clk_in),
            .rst_n_in    (rst_n),
            .clk_en_in   (clk_en_in),
            .pin_in      (pin_level[p]),
            .edge_sel_in (pin_sel[p]),
            .hit_out     (pin_hit[p])
         );
      end
   endgenerate

   // each source drives its own flag bit
   assign hw_set[`MIFC_SRC_LOW_VOLT]  = low_voltage_request_in;
   assign hw_set[`MIFC_SRC_PIN0]      = pin_hit[0];
   assign hw_set[`MIFC_SRC_PIN1]      = pin_hit[1];
   assign hw_set[`MIFC_SRC_TMR_H1]    = timer_h1_match_in;
   assign hw_set[`MIFC_SRC_TMR_00_0]  = timer_00_ch0_in;
   assign hw_set[`MIFC_SRC_TMR_00_1]  = timer_00_ch1_in;
   assign hw_set[`MIFC_SRC_CONV_DONE] = conversion_done_request_in;
   assign hw_set[`MIFC_SRC_PIN2]      = pin_hit[2];
   assign hw_set[`MIFC_SRC_PIN3]      = pin_hit[3];
   assign hw_set[`MIFC_SRC_TMR_80]    = timer_80_match_in;
   assign hw_set[`MIFC_SRC_RX_ERR]    = serial_rx_error_request_in;
   assign hw_set[`MIFC_SRC_RX_DONE]   = serial_rx_done_request_in;
   assign hw_set[`MIFC_SRC_TX_DONE]   = serial_tx_done_request_in;

   generate
      for (genvar s = 0; s < `MIFC_NUM_SRC; s++) begin : g_ack
         assign ack_clr[s] = cpu_ack_in & (cpu_ack_index_in == 4'(s));
      end
   endgenerate

   // software write first, then acknowledge clear, then hardware set wins
   always_comb begin
      next_flags = flags;
      if (wr_hit && reg_id == mifc_pkg::REG_FLAGS_LO) begin
         next_flags[7:0] = wr_byte;
      end
      if (wr_hit && reg_id == mifc_pkg::REG_FLAGS_HI) begin
         next_flags[`MIFC_NUM_SRC-1:8] = wr_byte[`MIFC_HI_BITS-1:0];
      end
      next_flags = (next_flags & ~ack_clr) | hw_set;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         flags <= RST_FLAGS_WORD[`MIFC_NUM_SRC-1:0];
      end else if (clk_en_in) begin
         flags <= next_flags;
      end
   end

   always_comb begin
      next_masks = masks;
      if (wr_hit && reg_id == mifc_pkg::REG_MASK_LO) begin
         next_masks[7:0] = wr_byte;
      end
      if (wr_hit && reg_id == mifc_pkg::REG_MASK_HI) begin
         next_masks[`MIFC_NUM_SRC-1:8] = wr_byte[`MIFC_HI_BITS-1:0];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         masks <= RST_MASK_WORD[`MIFC_NUM_SRC-1:0];
      end else if (clk_en_in) begin
         masks <= next_masks;
      end
   end

   // edge registers: whole-byte writes only, bit operations are dropped
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         edge_sel0 <= `MIFC_RST_EDGE_SEL;
         edge_sel1 <= `MIFC_RST_EDGE_SEL;
      end else if (wr_hit && !req.bit_op) begin
         if (reg_id == mifc_pkg::REG_EDGE_SEL0) begin
            edge_sel0 <= req.wdata & `MIFC_EDGE_SEL0_WMASK;
         end
         if (reg_id == mifc_pkg::REG_EDGE_SEL1) begin
            edge_sel1 <= req.wdata & `MIFC_EDGE_SEL1_WMASK;
         end
      end
   end

   // read data registered, holds until the next read
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rdata_out <= 8'h00;
      end else if (clk_en_in && req.rd) begin
         cpu_rdata_out <= cur_byte;
      end
   end

   mifc_priority u_priority (
      .flags_in (flags),
      .masks_in (masks),
      .pick_out (pick)
   );

   // the presented request is held while flags or masks are being touched,
   // so the core never sees a half-updated choice
   always_comb begin
      case (reg_id)
         mifc_pkg::REG_FLAGS_LO,
         mifc_pkg::REG_FLAGS_HI,
         mifc_pkg::REG_MASK_LO,
         mifc_pkg::REG_MASK_HI: flag_access = req.wr | req.rd;
         default:               flag_access = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_pending_out <= 1'b0;
         irq_index_out   <= 4'h0;
      end else if (clk_en_in && !flag_access) begin
         irq_pending_out <= pick.valid;
         irq_index_out   <= pick.index;
      end
   end

   // copies for the core, straight from flops
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         request_flags_out <= RST_FLAGS_WORD[`MIFC_NUM_SRC-1:0];
      end else if (clk_en_in) begin
         request_flags_out <= next_flags;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mask_flags_out <= RST_MASK_WORD[`MIFC_NUM_SRC-1:0];
      end else if (clk_en_in) begin
         mask_flags_out <= next_masks;
      end
   end

endmodule : mifc_top
`default_nettype wire

// file: mifc_regs.svh
`ifndef MIFC_REGS_SVH
`define MIFC_REGS_SVH

// register byte addresses
`define MIFC_ADDR_FLAGS_LO   16'hFFE0
`define MIFC_ADDR_FLAGS_HI   16'hFFE1
`define MIFC_ADDR_MASK_LO    16'hFFE4
`define MIFC_ADDR_MASK_HI    16'hFFE5
`define MIFC_ADDR_EDGE_SEL0  16'hFFEC
`define MIFC_ADDR_EDGE_SEL1  16'hFFED

// reset values
`define MIFC_RST_FLAGS       8'h00
`define MIFC_RST_MASK        8'hFF
`define MIFC_RST_EDGE_SEL    8'h00

// writable bits of the edge-select registers, reserved bits read zero
`define MIFC_EDGE_SEL0_WMASK 8'hFC
`define MIFC_EDGE_SEL1_WMASK 8'h03

// edge-select field positions (lsb of each 2-bit field)
`define MIFC_PIN0_EDGE_LSB   2
`define MIFC_PIN1_EDGE_LSB   4
`define MIFC_PIN2_EDGE_LSB   6
`define MIFC_PIN3_EDGE_LSB   0

// source bit positions, also fixed priority order (0 is highest)
`define MIFC_NUM_SRC         13
`define MIFC_HI_BITS         5
`define MIFC_SRC_LOW_VOLT    0
`define MIFC_SRC_PIN0        1
`define MIFC_SRC_PIN1        2
`define MIFC_SRC_TMR_H1      3
`define MIFC_SRC_TMR_00_0    4
`define MIFC_SRC_TMR_00_1    5
`define MIFC_SRC_CONV_DONE   6
`define MIFC_SRC_PIN2        7
`define MIFC_SRC_PIN3        8
`define MIFC_SRC_TMR_80      9
`define MIFC_SRC_RX_ERR      10
`define MIFC_SRC_RX_DONE     11
`define MIFC_SRC_TX_DONE     12

`endif

// file: mifc_pkg.sv
package mifc_pkg;

   typedef enum logic [1:0] {
      EDGE_FALL = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_BAD  = 2'b10,
      EDGE_BOTH = 2'b11
   } mifc_edge_t;

   typedef enum logic [2:0] {
      REG_NONE      = 3'b000,
      REG_FLAGS_LO  = 3'b001,
      REG_FLAGS_HI  = 3'b010,
      REG_MASK_LO   = 3'b011,
      REG_MASK_HI   = 3'b100,
      REG_EDGE_SEL0 = 3'b101,
      REG_EDGE_SEL1 = 3'b110
   } mifc_reg_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic        bit_op;
      logic [2:0]  bit_sel;
      logic        bit_val;
      logic [7:0]  wdata;
   } mifc_cpu_req_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] index;
   } mifc_pick_t;

endpackage : mifc_pkg

// file: mifc_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module mifc_edge_detect (
   // clock and control
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       clk_en_in,
   // pin and mode
   input  wire logic       pin_in,
   input  wire logic [1:0] edge_sel_in,
   // event
   output logic            hit_out
);

   logic sync_a;
   logic sync_b;
   logic prev;
   logic armed;
   logic rise;
   logic fall;

   // two-stage synchroniser, sync_a feeds sync_b only
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else if (clk_en_in) begin
         sync_a <= pin_in;
         sync_b <= sync_a;
      end
   end

   // first sample after reset only primes prev, from the still-zero sync_b, so an idle-high pin still makes one rising edge
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev  <= 1'b0;
         armed <= 1'b0;
      end else if (clk_en_in) begin
         prev  <= sync_b;
         armed <= 1'b1;
      end
   end

   assign rise = armed & ~prev & sync_b;
   assign fall = armed & prev & ~sync_b;

   always_comb begin
      case (mifc_pkg::mifc_edge_t'(edge_sel_in))
         mifc_pkg::EDGE_FALL: hit_out = fall;
         mifc_pkg::EDGE_RISE: hit_out = rise;
         mifc_pkg::EDGE_BOTH: hit_out = rise | fall;
         default:             hit_out = 1'b0;
      endcase
   end

endmodule : mifc_edge_detect
`default_nettype wire

// file: mifc_priority.sv
`timescale 1ns/1ps
`default_nettype none
`include "mifc_regs.svh"
module mifc_priority (
   // flags
   input  wire logic [`MIFC_NUM_SRC-1:0] flags_in,
   input  wire logic [`MIFC_NUM_SRC-1:0] masks_in,
   // choice
   output mifc_pkg::mifc_pick_t          pick_out
);

   logic [`MIFC_NUM_SRC-1:0] eligible;

   assign eligible = flags_in & ~masks_in;

   // scan from lowest priority up so the highest eligible one wins
   always_comb begin
      pick_out.valid = 1'b0;
      pick_out.index = 4'h0;
      for (int i = `MIFC_NUM_SRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            pick_out.valid = 1'b1;
            pick_out.index = 4'(i);
         end
      end
   end

endmodule : mifc_priority
`default_nettype wire

// file: mifc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mifc_regs.svh"
module mifc_chk (
   // clock and reset
   input wire logic        ref_clk_in,
   input wire logic        reset_n_in,
   input wire logic        clk_en_in,
   // cpu side
   input wire logic [15:0] cpu_addr_in,
   input wire logic        cpu_wr_in,
   input wire logic        cpu_rd_in,
   input wire logic        cpu_bit_op_in,
   input wire logic [2:0]  cpu_bit_sel_in,
   input wire logic        cpu_bit_val_in,
   input wire logic [7:0]  cpu_wdata_in,
   input wire logic [7:0]  cpu_rdata_out,
   input wire logic        cpu_ack_in,
   input wire logic [3:0]  cpu_ack_index_in,
   // sources
   input wire logic        low_voltage_request_in,
   input wire logic        timer_80_match_in,
   // request
   input wire logic        irq_pending_out,
   input wire logic [3:0]  irq_index_out,
   input wire logic [12:0] request_flags_out,
   input wire logic [12:0] mask_flags_out
);
   logic [12:0] elig;
   logic [3:0]  pick;
   logic [3:0]  prev_pick;
   logic        prev_any;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   assign elig = request_flags_out & ~mask_flags_out;

   // lowest index wins, so scan downwards
   always_comb begin
      pick = 4'h0;
      for (int i = 12; i >= 0; i--) begin
         if (elig[i]) begin
            pick = 4'(i);
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prev_any  <= 1'b0;
         prev_pick <= 4'h0;
      end else begin
         prev_any  <= |elig;
         prev_pick <= pick;
      end
   end

   chk_reset_values: assert property ($rose(reset_n_in) |->
      (mask_flags_out == 13'h1FFF) && (request_flags_out == 13'h0000))
      else $error("flag or mask value wrong at reset release");
   chk_source_sets: assert property (clk_en_in && low_voltage_request_in |=>
      request_flags_out[0]) else $error("source pulse did not set its flag");
   chk_ack_clears: assert property (clk_en_in && cpu_ack_in && cpu_ack_index_in == 4'h9
      && !timer_80_match_in && !cpu_wr_in |=> !request_flags_out[9])
      else $error("acknowledge did not clear the flag");
   chk_mask_byte: assert property (clk_en_in && cpu_wr_in && !cpu_bit_op_in
      && cpu_addr_in == `MIFC_ADDR_MASK_LO |=> mask_flags_out[7:0] == $past(cpu_wdata_in))
      else $error("mask byte write not taken");
   chk_mask_bit: assert property (clk_en_in && cpu_wr_in && cpu_bit_op_in && cpu_bit_sel_in < 3'h5
      && cpu_addr_in == `MIFC_ADDR_MASK_HI |=>
      mask_flags_out[{1'b1, $past(cpu_bit_sel_in)}] == $past(cpu_bit_val_in))
      else $error("mask bit write not taken");
   chk_flag_sw_set: assert property (clk_en_in && cpu_wr_in && !cpu_bit_op_in
      && cpu_addr_in == `MIFC_ADDR_FLAGS_LO |=>
      (request_flags_out[7:0] & $past(cpu_wdata_in)) == $past(cpu_wdata_in))
      else $error("written one did not set the flag");
   chk_mask_read: assert property (clk_en_in && cpu_rd_in && !cpu_wr_in
      && cpu_addr_in == `MIFC_ADDR_MASK_LO |=> cpu_rdata_out == $past(mask_flags_out[7:0]))
      else $error("mask read returned wrong byte");
   chk_pend_cause: assert property ($rose(irq_pending_out) |->
      prev_any && (irq_index_out == prev_pick))
      else $error("request raised without cause or with wrong index");
   chk_pend_drop: assert property ($fell(irq_pending_out) |-> !prev_any)
      else $error("request dropped while a source was eligible");
endmodule : mifc_chk
`default_nettype wire

// file: mifc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mifc_cpu_model (
   // core side
   input  wire logic       clk_in,
   input  wire logic       pending_in,
   input  wire logic [3:0] index_in,
   // behaviour select
   input  wire logic       auto_in,
   input  wire logic       slow_in,
   // acknowledge
   output logic            ack_out,
   output logic [3:0]      ack_index_out
);
   // extra idle edge after each ack lets the registered request catch up
   initial begin
      ack_out       = 1'b0;
      ack_index_out = 4'hF;
      forever begin
         @(posedge clk_in);
         #1;
         if (auto_in && pending_in) begin
            if (slow_in) begin
               repeat (6) @(posedge clk_in);
               #1;
            end
            ack_index_out = index_in;
            ack_out       = 1'b1;
            @(posedge clk_in);
            #1;
            ack_out       = 1'b0;
            ack_index_out = 4'hF;
            @(posedge clk_in);
         end
      end
   end
endmodule : mifc_cpu_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mifc_regs.svh"
module tb_top;
   logic        ref_clk_in;
   logic        reset_n_in;
   logic        clk_en_in;
   logic [15:0] cpu_addr_in;
   logic        cpu_wr_in;
   logic        cpu_rd_in;
   logic        cpu_bit_op_in;
   logic [2:0]  cpu_bit_sel_in;
   logic        cpu_bit_val_in;
   logic [7:0]  cpu_wdata_in;
   logic [7:0]  cpu_rdata_out;
   logic        cpu_ack_in;
   logic [3:0]  cpu_ack_index_in;
   logic [8:0]  src;
   logic [3:0]  pins;
   logic        irq_pending_out;
   logic [3:0]  irq_index_out;
   logic [12:0] request_flags_out;
   logic [12:0] mask_flags_out;
   logic        auto_ack;
   logic        slow_ack;
   int          n_errors;
   int          checked;
   localparam int SIDX [9] = '{0, 3, 4, 5, 6, 9, 10, 11, 12};
   localparam int PIDX [4] = '{1, 2, 7, 8};

   always #2.5 ref_clk_in = ~ref_clk_in;

   mifc_top mifc_top_i (.ref_clk_in, .reset_n_in, .clk_en_in, .cpu_addr_in, .cpu_wr_in,
      .cpu_rd_in, .cpu_bit_op_in, .cpu_bit_sel_in, .cpu_bit_val_in, .cpu_wdata_in,
      .cpu_rdata_out, .cpu_ack_in, .cpu_ack_index_in, .low_voltage_request_in(src[0]),
      .timer_h1_match_in(src[1]), .timer_00_ch0_in(src[2]), .timer_00_ch1_in(src[3]),
      .conversion_done_request_in(src[4]), .timer_80_match_in(src[5]),
      .serial_rx_error_request_in(src[6]), .serial_rx_done_request_in(src[7]),
      .serial_tx_done_request_in(src[8]), .ext_irq_pin0_in(pins[0]),
      .ext_irq_pin1_in(pins[1]), .ext_irq_pin2_in(pins[2]), .ext_irq_pin3_in(pins[3]),
      .irq_pending_out, .irq_index_out, .request_flags_out, .mask_flags_out);

   mifc_cpu_model mifc_cpu_model_i (.clk_in(ref_clk_in), .pending_in(irq_pending_out),
      .index_in(irq_index_out), .auto_in(auto_ack), .slow_in(slow_ack),
      .ack_out(cpu_ack_in), .ack_index_out(cpu_ack_index_in));

   task automatic tick;
      @(posedge ref_clk_in);
      #1;
   endtask : tick

   task automatic close_out;
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // strobes drop one edge after taking, so back-to-back calls never collide
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      tick;
      cpu_addr_in   = a;
      cpu_bit_op_in = 1'b0;
      cpu_wdata_in  = d;
      cpu_wr_in     = 1'b1;
      tick;
      cpu_wr_in     = 1'b0;
   endtask : wr

   task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
      tick;
      cpu_addr_in    = a;
      cpu_bit_op_in  = 1'b1;
      cpu_bit_sel_in = s;
      cpu_bit_val_in = v;
      cpu_wr_in      = 1'b1;
      tick;
      cpu_wr_in      = 1'b0;
   endtask : bw

   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      tick;
      cpu_addr_in = a;
      cpu_rd_in   = 1'b1;
      tick;
      cpu_rd_in   = 1'b0;
      cmp({5'h00, cpu_rdata_out}, {5'h00, e});
   endtask : rdc

   task automatic clr_flags;
      wr(`MIFC_ADDR_FLAGS_LO, 8'h00);
      wr(`MIFC_ADDR_FLAGS_HI, 8'h00);
   endtask : clr_flags

   task automatic t_regs;
      rdc(`MIFC_ADDR_FLAGS_LO, 8'h00);
      rdc(`MIFC_ADDR_FLAGS_HI, 8'h00);
      rdc(`MIFC_ADDR_MASK_LO, 8'hFF);
      rdc(`MIFC_ADDR_MASK_HI, 8'hFF);
      rdc(`MIFC_ADDR_EDGE_SEL0, 8'h00);
      rdc(`MIFC_ADDR_EDGE_SEL1, 8'h00);
      rdc(16'h0000, 8'h00);
      bw(`MIFC_ADDR_EDGE_SEL0, 3'h2, 1'b1);
      rdc(`MIFC_ADDR_EDGE_SEL0, 8'h00);
      wr(`MIFC_ADDR_EDGE_SEL0, 8'hFF);
      rdc(`MIFC_ADDR_EDGE_SEL0, 8'hFC);
      wr(`MIFC_ADDR_EDGE_SEL1, 8'hFF);
      rdc(`MIFC_ADDR_EDGE_SEL1, 8'h03);
      wr(`MIFC_ADDR_FLAGS_HI, 8'hFF);
      rdc(`MIFC_ADDR_FLAGS_HI, 8'h1F);
      wr(`MIFC_ADDR_FLAGS_LO, 8'hA5);
      bw(`MIFC_ADDR_FLAGS_LO, 3'h6, 1'b1);
      rdc(`MIFC_ADDR_FLAGS_LO, 8'hE5);
      clr_flags;
      rdc(`MIFC_ADDR_FLAGS_HI, 8'h00);
      wr(`MIFC_ADDR_MASK_LO, 8'h5A);
      rdc(`MIFC_ADDR_MASK_LO, 8'h5A);
      bw(`MIFC_ADDR_MASK_LO, 3'h0, 1'b1);
      rdc(`MIFC_ADDR_MASK_LO, 8'h5B);
      bw(`MIFC_ADDR_MASK_HI, 3'h4, 1'b0);
      rdc(`MIFC_ADDR_MASK_HI, 8'hEF);
      wr(`MIFC_ADDR_EDGE_SEL0, 8'h00);
      wr(`MIFC_ADDR_EDGE_SEL1, 8'h00);
      wr(`MIFC_ADDR_MASK_LO, 8'hFF);
      wr(`MIFC_ADDR_MASK_HI, 8'hFF);
   endtask : t_regs

   task automatic t_sources;
      for (int i = 0; i < 9; i++) begin
         tick;
         src = 9'h001 << i;
         tick;
         src = 9'h000;
         cmp(request_flags_out, 13'h0001 << SIDX[i]);
         clr_flags;
         cmp(request_flags_out, 13'h0000);
      end
      // with the enable low a source pulse must leave every flag alone
      clk_en_in = 1'b0;
      src       = 9'h001;
      repeat (2) tick;
      src       = 9'h000;
      clk_en_in = 1'b1;
      tick;
      cmp(request_flags_out, 13'h0000);
   endtask : t_sources

   task automatic pin_step(input int p, input logic lvl, input logic hit);
      tick;
      pins[p] = lvl;
      repeat (5) tick;
      cmp(request_flags_out, hit ? 13'h0001 << PIDX[p] : 13'h0000);
      clr_flags;
   endtask : pin_step

   // masks stay set throughout, as software must before touching edge modes
   task automatic t_pins;
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 4; m++) begin
            if (p == 3) begin
               wr(`MIFC_ADDR_EDGE_SEL1, 8'(m));
            end else begin
               wr(`MIFC_ADDR_EDGE_SEL0, 8'(m << (2 * p + 2)));
            end
            clr_flags;
            pin_step(p, 1'b0, m == 0 || m == 3);
            pin_step(p, 1'b1, m == 1 || m == 3);
         end
      end
   endtask : t_pins

   task automatic t_prio;
      auto_ack = 1'b1;
      for (int s = 0; s < 2; s++) begin
         slow_ack = s[0];
         wr(`MIFC_ADDR_MASK_LO, 8'h00);
         wr(`MIFC_ADDR_MASK_HI, 8'h00);
         tick;
         src = 9'h0A0;
         tick;
         src = 9'h000;
         tick;
         cmp({8'h00, irq_pending_out, irq_index_out}, 13'h0019);
         for (int n = 0; n < 40 && request_flags_out !== 13'h0000; n++) begin
            tick;
         end
         cmp(request_flags_out, 13'h0000);
         if (request_flags_out !== 13'h0000) begin
            close_out;
         end
         repeat (2) tick;
         cmp({12'h000, irq_pending_out}, 13'h0000);
      end
      wr(`MIFC_ADDR_MASK_LO, 8'hFF);
      wr(`MIFC_ADDR_MASK_HI, 8'hFF);
      tick;
      src = 9'h001;
      tick;
      src = 9'h000;
      repeat (3) tick;
      cmp({11'h000, irq_pending_out, request_flags_out[0]}, 13'h0001);
      clr_flags;
   endtask : t_prio

   initial begin
      ref_clk_in     = 1'b0;
      reset_n_in     = 1'b0;
      clk_en_in      = 1'b1;
      cpu_addr_in    = 16'h0000;
      cpu_wr_in      = 1'b0;
      cpu_rd_in      = 1'b0;
      cpu_bit_op_in  = 1'b0;
      cpu_bit_sel_in = 3'h0;
      cpu_bit_val_in = 1'b0;
      cpu_wdata_in   = 8'h00;
      src            = 9'h000;
      pins           = 4'hF;
      auto_ack       = 1'b0;
      slow_ack       = 1'b0;
      n_errors       = 0;
      checked        = 0;
      repeat (20) @(posedge ref_clk_in);
      #1;
      reset_n_in = 1'b1;
      repeat (4) tick;
      t_regs;
      t_sources;
      t_pins;
      t_prio;
      close_out;
   end
endmodule : tb_top

bind mifc_top mifc_chk mifc_chk_i (.ref_clk_in, .reset_n_in, .clk_en_in, .cpu_addr_in,
   .cpu_wr_in, .cpu_rd_in, .cpu_bit_op_in, .cpu_bit_sel_in, .cpu_bit_val_in, .cpu_wdata_in,
   .cpu_rdata_out, .cpu_ack_in, .cpu_ack_index_in, .low_voltage_request_in,
   .timer_80_match_in, .irq_pending_out, .irq_index_out, .request_flags_out,
   .mask_flags_out);
`default_nettype wire
